// ---- design/wdtm_pkg.sv ----
// Purpose: Constants for the watchdog timer block
// Assumes: 8-bit registers reached over a plain strobe port
// Notes:   Offsets of the register port are local choices
package wdtm_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] WDTM_OFF_CTRL   = 4'h0;
    localparam logic [3:0] WDTM_OFF_SYS    = 4'h1;
    localparam logic [3:0] WDTM_OFF_STAT   = 4'h2;
    localparam logic [3:0] WDTM_OFF_IRQST  = 4'h3;
    localparam logic [3:0] WDTM_OFF_IRQMSK = 4'h4;
    // ----------------------------------------------------------------
    // Field positions and codes
    // ----------------------------------------------------------------
    localparam int         WDTM_KEY_LSB    = 3;
    localparam logic [4:0] WDTM_KEY_ON     = 5'h0a;
    localparam logic [4:0] WDTM_KEY_OFF    = 5'h15;
    localparam int         WDTM_SYS_FAULT  = 0;
    localparam int         WDTM_SYS_FSYS   = 7;
    localparam int         WDTM_ST_EXPIRY  = 0;
    localparam int         WDTM_ST_PDOWN   = 1;
    localparam int         WDTM_EV_EXPIRY  = 0;
    localparam int         WDTM_EV_FAULT   = 1;
    localparam int         WDTM_EV_WAKE    = 2;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] WDTM_CTRL_RST   = 8'h53;
    localparam logic [7:0] WDTM_SYS_RST    = 8'h00;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int         WDTM_PER_MIN_LOG2 = 8;
    localparam int         WDTM_CNT_W        = 16;
    localparam int         WDTM_FAULT_DLY    = 2;
    localparam int         WDTM_SYNC_W       = 2;
endpackage

// ---- design/wdtm_tick_sync.sv ----
// Purpose: Brings the slow oscillator clock into clk_i as tick pulses
// Assumes: Slow clock far slower than clk_i
// Notes:   Two-stage synchroniser, then rising-edge detect
`timescale 1ns/1ps
`default_nettype none
module wdtm_tick_sync
    import wdtm_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Slow clock in, tick out
    input  wire logic slow_clk_i,
    output var  logic tick_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic tick;
    } wdtm_sync_s;

    wdtm_sync_s st_r;
    wdtm_sync_s st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = slow_clk_i;
        st_nxt.s2   = st_r.s1;
        st_nxt.s3   = st_r.s2;
        st_nxt.tick = st_r.s2 & ~st_r.s3;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;
endmodule
`default_nettype wire

// ---- design/wdtm_top.sv ----
// Purpose: Watchdog timer with key field, period select and flags
// Assumes: Core gives one-cycle clear and halt signals and a sleep-mode level
// Notes:   All timing counted in slow oscillator ticks
//
// How it works
// - The watchdog counts only ticks of the slow internal oscillator.
// - Period select codes 0 to 7 give 256 up to 32768 slow cycles.
// - A static option picks always-enabled or key-controlled operation.
// - Always-enabled keeps counting with either defined key code.
// - Key-controlled disables on the off code and enables on the on code.
// - An undefined key resets the device two to three slow cycles later.
// - That reset sets the key-fault flag in bit 0 of the system register.
// - Only a software write of zero clears the key-fault flag.
// - Power-on gives key 01010B and period select 011.
// - A timeout in normal operation resets the device and sets expiry.
// - A timeout in sleep or idle sets expiry and resets only PC and SP.
// - Key fault, the clear instruction or halt restart the count.
// - System register bits 6 to 3 read as zero.
// - Power-down flag clears on power-up or clear, sets on halt.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wdtm_top
    import wdtm_pkg::*;
#(
    parameter int CNT_W = WDTM_CNT_W
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // Slow oscillator and static option
    input  wire logic       slow_internal_osc_i,
    input  wire logic       always_on_opt_i,
    // Core events
    input  wire logic       guard_clear_instruction_i,
    input  wire logic       halt_instruction_i,
    input  wire logic       low_power_mode_i,
    // Register port
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output var  logic [7:0] rdata_o,
    // Reset requests and interrupt
    output var  logic       device_reset_o,
    output var  logic       pc_sp_reset_o,
    output var  logic       irq_o
);
    if (CNT_W < 16) begin : g_cnt_w_chk
        $error("CNT_W too small for the longest period");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       ctrl;
        logic             fsys;
        logic             fault;
        logic             expiry;
        logic             pdown;
        logic [CNT_W-1:0] cnt;
        logic [1:0]       fdly;
        logic [2:0]       ev;
        logic [2:0]       mask;
        logic [7:0]       rdata;
        logic             dev_rst;
        logic             pcsp_rst;
        logic             irq;
    } wdtm_state_s;

    wdtm_state_s st_r;
    wdtm_state_s st_nxt;
    logic        tick;

    wdtm_tick_sync u_sync (
        .clk_i      (clk_i),
        .reset_n_i  (reset_n_i),
        .slow_clk_i (slow_internal_osc_i),
        .tick_o     (tick)
    );

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic key_valid(input logic [4:0] k);
        key_valid = (k == WDTM_KEY_ON) || (k == WDTM_KEY_OFF);
    endfunction

    function automatic logic [CNT_W-1:0] period_of(input logic [2:0] s);
        period_of = CNT_W'(1) << (WDTM_PER_MIN_LOG2 + int'(s));
    endfunction

    logic [4:0] key;
    logic       run;
    logic       expire;
    logic       clr;
    logic       fault_fire;
    assign key = st_r.ctrl[7:WDTM_KEY_LSB];
    // Enable from option and key
    assign run = key_valid(key) &&
                 (always_on_opt_i || key == WDTM_KEY_ON);
    assign clr = guard_clear_instruction_i | halt_instruction_i;
    // Expire at last count of the period
    assign expire = run && tick && !clr &&
                    (st_r.cnt == period_of(st_r.ctrl[2:0]) - 1'b1);
    assign fault_fire = tick && !key_valid(key) &&
                        (st_r.fdly == 2'(WDTM_FAULT_DLY));

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt          = st_r;
        st_nxt.dev_rst  = 1'b0;
        st_nxt.pcsp_rst = 1'b0;
        st_nxt.rdata    = 8'h00;

        // Counter
        if (clr || !key_valid(key) || expire) begin
            st_nxt.cnt = '0;
        end else if (run && tick) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end

        // Key fault delay
        if (key_valid(key)) begin
            st_nxt.fdly = '0;
        end else if (tick && !fault_fire) begin
            st_nxt.fdly = st_r.fdly + 1'b1;
        end

        // Register writes
        if (wr_i) begin
            if (addr_i == WDTM_OFF_CTRL) begin
                st_nxt.ctrl = wdata_i;
            end else if (addr_i == WDTM_OFF_SYS) begin
                st_nxt.fsys = wdata_i[WDTM_SYS_FSYS];
                if (!wdata_i[WDTM_SYS_FAULT]) begin
                    st_nxt.fault = 1'b0;
                end
            end else if (addr_i == WDTM_OFF_IRQST) begin
                st_nxt.ev = st_r.ev & ~wdata_i[2:0];
            end else if (addr_i == WDTM_OFF_IRQMSK) begin
                st_nxt.mask = wdata_i[2:0];
            end
        end

        // Power-down flag
        if (halt_instruction_i) begin
            st_nxt.pdown  = 1'b1;
            st_nxt.expiry = 1'b0;
        end else if (guard_clear_instruction_i) begin
            st_nxt.pdown  = 1'b0;
        end

        // Key fault reset, key back to power-on value
        if (fault_fire) begin
            st_nxt.fault   = 1'b1;
            st_nxt.dev_rst = 1'b1;
            st_nxt.ctrl    = WDTM_CTRL_RST;
            st_nxt.ev[WDTM_EV_FAULT] = 1'b1;
        end

        // Timeout
        if (expire) begin
            st_nxt.expiry = 1'b1;
            st_nxt.ev[WDTM_EV_EXPIRY] = 1'b1;
            if (low_power_mode_i) begin
                st_nxt.pcsp_rst = 1'b1;
                st_nxt.ev[WDTM_EV_WAKE] = 1'b1;
            end else begin
                st_nxt.dev_rst = 1'b1;
            end
        end

        // Reads
        if (rd_i) begin
            if (addr_i == WDTM_OFF_CTRL) begin
                st_nxt.rdata = st_r.ctrl;
            end else if (addr_i == WDTM_OFF_SYS) begin
                st_nxt.rdata = {st_r.fsys, 4'h0, 2'b00,
                                st_r.fault};
            end else if (addr_i == WDTM_OFF_STAT) begin
                st_nxt.rdata = {6'h00, st_r.pdown, st_r.expiry};
            end else if (addr_i == WDTM_OFF_IRQST) begin
                st_nxt.rdata = {5'h00, st_r.ev};
            end else if (addr_i == WDTM_OFF_IRQMSK) begin
                st_nxt.rdata = {5'h00, st_r.mask};
            end
        end

        st_nxt.irq = |(st_nxt.ev & st_nxt.mask);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r      <= '0;
            st_r.ctrl <= WDTM_CTRL_RST;
            st_r.fsys <= WDTM_SYS_RST[WDTM_SYS_FSYS];
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o        = st_r.rdata;
    assign device_reset_o = st_r.dev_rst;
    assign pc_sp_reset_o  = st_r.pcsp_rst;
    assign irq_o          = st_r.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_bad_key_ticks;
        (!key_valid(key) && tick) ##1 (!key_valid(key) && !tick) [*1];
    endsequence

    property p_fault_sets_flag;
        @(posedge clk_i) disable iff (!reset_n_i)
        fault_fire |=> (st_r.fault && device_reset_o);
    endproperty
    a_fault_sets_flag: assert property (p_fault_sets_flag)
        else $error("key fault did not set flag and reset");

    property p_fault_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        (st_r.fault && !(wr_i && addr_i == WDTM_OFF_SYS &&
         !wdata_i[WDTM_SYS_FAULT])) |=> st_r.fault;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("key fault flag cleared without write");

    property p_good_key_no_reset;
        @(posedge clk_i) disable iff (!reset_n_i)
        (key_valid(key) && !expire) |=> !device_reset_o;
    endproperty
    a_good_key_no_reset: assert property (p_good_key_no_reset)
        else $error("device reset with valid key");

    property p_off_no_count;
        @(posedge clk_i) disable iff (!reset_n_i)
        (!always_on_opt_i && key == WDTM_KEY_OFF) |=> st_r.cnt == '0
            || $stable(st_r.cnt);
    endproperty
    a_off_no_count: assert property (p_off_no_count)
        else $error("counter moved while disabled");

    property p_clear_zero;
        @(posedge clk_i) disable iff (!reset_n_i)
        clr |=> st_r.cnt == '0;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("clear did not zero counter");

    property p_expire_normal;
        @(posedge clk_i) disable iff (!reset_n_i)
        (expire && !low_power_mode_i) |=>
            (device_reset_o && st_r.expiry && !pc_sp_reset_o);
    endproperty
    a_expire_normal: assert property (p_expire_normal)
        else $error("normal timeout did not reset device");

    property p_expire_sleep;
        @(posedge clk_i) disable iff (!reset_n_i)
        (expire && low_power_mode_i) |=>
            (pc_sp_reset_o && st_r.expiry && !device_reset_o);
    endproperty
    a_expire_sleep: assert property (p_expire_sleep)
        else $error("sleep timeout handled wrongly");

    property p_halt_pdown;
        @(posedge clk_i) disable iff (!reset_n_i)
        halt_instruction_i |=> (st_r.pdown && !st_r.expiry);
    endproperty
    a_halt_pdown: assert property (p_halt_pdown)
        else $error("halt did not set power-down flag");

    property p_sys_reserved;
        @(posedge clk_i) disable iff (!reset_n_i)
        (rd_i && addr_i == WDTM_OFF_SYS) |=> rdata_o[6:3] == 4'h0;
    endproperty
    a_sys_reserved: assert property (p_sys_reserved)
        else $error("reserved system bits not zero");

    property p_bad_key_wait;
        @(posedge clk_i) disable iff (!reset_n_i)
        s_bad_key_ticks |-> !device_reset_o;
    endproperty
    a_bad_key_wait: assert property (p_bad_key_wait)
        else $error("key fault reset came too early");

    property p_fault_restore;
        @(posedge clk_i) disable iff (!reset_n_i)
        fault_fire |=> st_r.ctrl == WDTM_CTRL_RST;
    endproperty
    a_fault_restore: assert property (p_fault_restore)
        else $error("key fault did not restore control");

    property p_pdown_clear;
        @(posedge clk_i) disable iff (!reset_n_i)
        (guard_clear_instruction_i && !halt_instruction_i) |=> !st_r.pdown;
    endproperty
    a_pdown_clear: assert property (p_pdown_clear)
        else $error("clear did not drop power-down flag");

    property p_hold_no_tick;
        @(posedge clk_i) disable iff (!reset_n_i)
        (!tick && !clr && key_valid(key)) |=> $stable(st_r.cnt);
    endproperty
    a_hold_no_tick: assert property (p_hold_no_tick)
        else $error("counter moved without a slow tick");

    property p_count_step;
        @(posedge clk_i) disable iff (!reset_n_i)
        (run && tick && !clr && !expire) |=>
            st_r.cnt == $past(st_r.cnt) + 1'b1;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step on a tick");

    property p_reset_pulse;
        @(posedge clk_i) disable iff (!reset_n_i)
        device_reset_o |=> !device_reset_o;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("device reset longer than one cycle");

    property p_sleep_keeps;
        @(posedge clk_i) disable iff (!reset_n_i)
        (expire && low_power_mode_i && !wr_i) |=>
            (st_r.ctrl == $past(st_r.ctrl) &&
             st_r.pdown == $past(st_r.pdown) &&
             st_r.fault == $past(st_r.fault));
    endproperty
    a_sleep_keeps: assert property (p_sleep_keeps)
        else $error("sleep timeout changed other state");

    property p_off_no_expire;
        @(posedge clk_i) disable iff (!reset_n_i)
        (!always_on_opt_i && key == WDTM_KEY_OFF) |-> !expire;
    endproperty
    a_off_no_expire: assert property (p_off_no_expire)
        else $error("timeout while key disables the watchdog");

    property p_always_on_runs;
        @(posedge clk_i) disable iff (!reset_n_i)
        (always_on_opt_i && key_valid(key)) |-> run;
    endproperty
    a_always_on_runs: assert property (p_always_on_runs)
        else $error("always-enabled watchdog not counting");
endmodule
`default_nettype wire

// ---- tb/wdtm_core_model.sv ----
// Purpose: Core model issuing clear and halt instructions
// Assumes: Bench commands one-shot clears, halts and periodic kicking
// Notes:   Low-power level holds from halt until wake or clear
`timescale 1ns/1ps
`default_nettype none
module wdtm_core_model
    import wdtm_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Bench commands
    input  wire logic kick_en_i,
    input  wire logic clr_req_i,
    input  wire logic halt_req_i,
    input  wire logic wake_i,
    // Core events
    output var  logic clear_o,
    output var  logic halt_o,
    output var  logic low_power_o
);
    logic [6:0] gap_r;
    // --------------------------------------------------------------
    // Instruction stream
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_r       <= 7'h00;
            clear_o     <= 1'b0;
            halt_o      <= 1'b0;
            low_power_o <= 1'b0;
        end else begin
            gap_r   <= kick_en_i ? gap_r + 7'h01 : 7'h00;
            clear_o <= clr_req_i | (kick_en_i && gap_r == 7'h7f);
            halt_o  <= halt_req_i;
            if (halt_req_i) begin
                low_power_o <= 1'b1;
            end else if (wake_i || clear_o) begin
                low_power_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/watchdog_timer_tb_top.sv ----
// Purpose: Self-checking bench for the watchdog timer
// Assumes: Slow clock ticks every 8 clk cycles
// Notes:   Timeouts measured as windows around the selected count
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_tb_top;
    import wdtm_pkg::*;
    logic clk_i = 1'b0, reset_n_i = 1'b0, slow = 1'b0, slow_run = 1'b1;
    logic always_on = 1'b0, kick = 1'b0, clr_req = 1'b0, halt_req = 1'b0;
    logic wr_i = 1'b0, rd_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, v;
    logic       dev_rst, pcsp_rst, irq_o, clr_w, halt_w, lp_w;
    logic [1:0] div_r = 2'h0;
    logic [4:0] key;
    logic       ok;
    int bad_count = 0, checked = 0, n;
    int seed = 32'h37ca9975;
    localparam int SLOW_PER = 8;
    // --------------------------------------------------------------
    // Clocks and instances
    // --------------------------------------------------------------
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        div_r <= div_r + 2'h1;
        if (slow_run && div_r == 2'h3) slow <= ~slow;
    end
    wdtm_top i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .slow_internal_osc_i(slow), .always_on_opt_i(always_on),
        .guard_clear_instruction_i(clr_w), .halt_instruction_i(halt_w),
        .low_power_mode_i(lp_w), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .device_reset_o(dev_rst), .pc_sp_reset_o(pcsp_rst), .irq_o(irq_o));
    wdtm_core_model i_core (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .kick_en_i(kick), .clr_req_i(clr_req), .halt_req_i(halt_req),
        .wake_i(dev_rst | pcsp_rst), .clear_o(clr_w), .halt_o(halt_w),
        .low_power_o(lp_w));
    // --------------------------------------------------------------
    // Tasks and functions
    // --------------------------------------------------------------
    function automatic int per_clk(input logic [2:0] code);
        return (256 << code) * SLOW_PER;
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic pulse_clr();
        @(posedge clk_i);
        clr_req <= 1'b1;
        @(posedge clk_i);
        clr_req <= 1'b0;
    endtask
    task automatic wait_exp(input logic [2:0] code, input logic pcsp);
        n = 0;
        while (!(dev_rst === 1'b1 || pcsp_rst === 1'b1)
               && n < per_clk(code) + 40) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check("expiry early", n >= per_clk(code) - 16, 1'b1);
        check("expiry late", n <= per_clk(code) + 24, 1'b1);
        check("pc_sp reset", pcsp_rst, pcsp);
        check("device reset", dev_rst, !pcsp);
    endtask
    task automatic quiet(input int cyc);
        int hits;
        hits = 0;
        repeat (cyc) begin
            @(posedge clk_i);
            #1;
            hits += (dev_rst === 1'b1);
        end
        check("quiet resets", hits != 0, 1'b0);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(60000 * 8);
        bad_count++;
        print_verdict();
    end
    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        do_reset();
        rd(WDTM_OFF_CTRL, v);
        check("ctrl reset", v, 8'h53);
        rd(WDTM_OFF_SYS, v);
        check("sys reset", v, 8'h00);
        rd(4'hf, v);
        check("unmapped", v, 8'h00);
        $display("test reset values done");
        wr(WDTM_OFF_IRQMSK, 8'h01);
        for (int c = 0; c < 2; c++) begin
            pulse_clr();
            wr(WDTM_OFF_CTRL, {WDTM_KEY_ON, 3'(c)});
            pulse_clr();
            wait_exp(3'(c), 1'b0);
            rd(WDTM_OFF_STAT, v);
            check("expiry flag", v[0], 1'b1);
            check("irq set", irq_o, 1'b1);
            wr(WDTM_OFF_IRQST, 8'h01);
            @(posedge clk_i);
            #1;
            check("irq cleared", irq_o, 1'b0);
        end
        $display("test periods done");
        wr(WDTM_OFF_CTRL, {WDTM_KEY_ON, 3'h0});
        pulse_clr();
        kick <= 1'b1;
        quiet(3000);
        @(posedge clk_i);
        kick <= 1'b0;
        pulse_clr();
        wr(WDTM_OFF_CTRL, {WDTM_KEY_OFF, 3'h0});
        quiet(3000);
        wr(WDTM_OFF_CTRL, {WDTM_KEY_ON, 3'h0});
        pulse_clr();
        slow_run <= 1'b0;
        quiet(3000);
        @(posedge clk_i);
        slow_run <= 1'b1;
        $display("test kick and disable done");
        always_on <= 1'b1;
        do_reset();
        wr(WDTM_OFF_IRQMSK, 8'h00);
        pulse_clr();
        wr(WDTM_OFF_CTRL, {WDTM_KEY_OFF, 3'h0});
        pulse_clr();
        wait_exp(3'h0, 1'b0);
        $display("test always enabled done");
        for (int i = 0; i < 3; i++) begin
            key = 5'($random(seed));
            if (key == WDTM_KEY_ON || key == WDTM_KEY_OFF) begin
                key = 5'h1f;
            end
            pulse_clr();
            wr(WDTM_OFF_CTRL, {key, 3'($random(seed))});
            n = 0;
            while (dev_rst !== 1'b1 && n < 60) begin
                @(posedge clk_i);
                #1;
                n++;
            end
            ok = n >= 2 * SLOW_PER && n <= 3 * SLOW_PER + 2;
            check("fault delay", ok, 1'b1);
            rd(WDTM_OFF_SYS, v);
            check("fault flag", v, 8'h01);
            rd(WDTM_OFF_CTRL, v);
            check("ctrl restored", v, 8'h53);
            rd(WDTM_OFF_IRQST, v);
            check("fault event", v[1], 1'b1);
            check("irq masked", irq_o, 1'b0);
            wr(WDTM_OFF_SYS, 8'hff);
            rd(WDTM_OFF_SYS, v);
            check("sys write ones", v, 8'h81);
            wr(WDTM_OFF_SYS, 8'h00);
            rd(WDTM_OFF_SYS, v);
            check("sys cleared", v, 8'h00);
            wr(WDTM_OFF_IRQST, 8'h07);
        end
        $display("test key fault done");
        wr(WDTM_OFF_CTRL, {WDTM_KEY_ON, 3'h0});
        pulse_clr();
        @(posedge clk_i);
        halt_req <= 1'b1;
        @(posedge clk_i);
        halt_req <= 1'b0;
        rd(WDTM_OFF_STAT, v);
        check("halt status", v, 8'h02);
        wait_exp(3'h0, 1'b1);
        rd(WDTM_OFF_STAT, v);
        check("sleep expiry", v[0], 1'b1);
        rd(WDTM_OFF_IRQST, v);
        check("sleep events", v, 8'h05);
        rd(WDTM_OFF_CTRL, v);
        check("sleep ctrl kept", v, 8'h50);
        pulse_clr();
        rd(WDTM_OFF_STAT, v);
        check("pd cleared", v[1], 1'b0);
        $display("test low power done");
        print_verdict();
    end
endmodule
`default_nettype wire
